// ### design/sts_sequencer.sv
// Self test and initialization sequencer with an APB register slave.
// Assumes APB master on pclk; init/test results come from device logic.
//
// Behaviour
// R1: Hard reset: inactive, failure line low, LED on
// R2: Init plus self test within 4.9 seconds
// R3: Init failing before access enabled stays put
// R4: Before access: passed 0, ready 1, fail asserted
// R5: Self test: only reset/inhibit accepted, bits cleared
// R6: Self test ends in failed or passed
// R7: Init failing after access: init-failed state
// R8: Failed: bits clear, fail asserted, reset exits
// R9: Passed: release failure line, passed set
// R10: Reset bit set enters soft reset
// R11: Soft reset drops interrupts, bus requests
// R12: Init-reset from init-failed; clearing restarts phase
// R13: Reset release starts init or self test
// R14: Failure line from passed and inhibit bits
// R15: Implement the five mandatory states
// R16: Without init sequence, never assert failure
// R17: Identity registers valid before self test
// R18: Early self test keeps ready at one
// R19: Comms ready before passed; dead goes failed
// R20: Register access stays enabled; soft reset keeps config
// R21: Logical address frozen after init-failed/self test
// R22: Stay deactivated until commander activates
// R23: Deactivated: no interrupt, no bus transfer
// R24: After init: enable access, clear ready, test
// R25: Limit counter on own clock, restarted on reset; here it runs on pclk
//
// The APB slave port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module sts_sequencer #(
  parameter bit HAS_INIT_SEQ = 1'b1,
  parameter bit HAS_CFG_INIT = 1'b1,
  parameter int LIMIT_CYC = sts_pkg::STS_LIMIT_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic system_reset_asserted,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic cfg_access_en,
  input wire logic cfg_init_done,
  input wire logic cfg_init_fail,
  input wire logic test_pass,
  input wire logic test_fail,
  input wire logic comm_ready,
  input wire logic dead,
  input wire logic irq_req,
  input wire logic bus_req,
  input wire logic [7:0] cfg_laddr,
  output logic sysfail_o,
  output logic sysfail_oe_n,
  output logic failed_led,
  output logic irq_out,
  output logic bus_req_out,
  output logic self_test_run
);
  import sts_pkg::*;

  typedef struct packed {
    sts_state_type state;
    logic reset_bit;
    logic inhibit;
    logic active;
    logic rm;
    logic passed;
    logic ready;
    logic access;
    logic timeout;
    logic system_reset_asserted_seen;
    logic [7:0] laddr;
    logic laddr_lock;
    logic [15:0] offset;
    logic space_active;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic sysfail_o;
    logic sysfail_oe_n;
    logic failed_led;
    logic irq_out;
    logic bus_req_out;
    logic self_test_run;
  } sts_st_type;

  sts_st_type st_q;
  sts_st_type st_d;
  sts_tmr_if tmr_bus();
  logic setup;
  logic wr_ctrl;
  logic wr_cfg;
  logic rst_set;
  logic rst_clr;
  logic full_cmds;
  logic [31:0] rdata;
  logic map_hit;

  sts_limit_timer #(
    .LIMIT_CYC(LIMIT_CYC)
  ) u_timer (
    .pclk(pclk),
    .presetn(presetn),
    .tmr(tmr_bus)
  );

  assign setup = psel && !penable;
  assign wr_ctrl = setup && pwrite && (paddr == STS_CTRL_OFS);
  assign wr_cfg = setup && pwrite && (paddr == STS_CFG_OFS);
  assign rst_set = wr_ctrl && pwdata[STS_CTRL_RESET_BIT] && !st_q.reset_bit;
  assign rst_clr = wr_ctrl && !pwdata[STS_CTRL_RESET_BIT] && st_q.reset_bit;
  // Commands beyond reset and inhibit only once passed
  assign full_cmds = (st_q.state == STS_PASSED); // R5 R11
  assign map_hit = (paddr == STS_CTRL_OFS) || (paddr == STS_STAT_OFS) ||
                   (paddr == STS_CFG_OFS) || (paddr == STS_ID_OFS);

  always_comb begin
    rdata = 32'h0000_0000;
    case (paddr)
      STS_CTRL_OFS: begin
        rdata[STS_CTRL_RESET_BIT] = st_q.reset_bit;
        rdata[STS_CTRL_INHIBIT_BIT] = st_q.inhibit;
        rdata[STS_CTRL_ACTIVATE_BIT] = st_q.active;
        rdata[STS_CTRL_RM_BIT] = st_q.rm;
      end
      STS_STAT_OFS: begin // R10
        rdata[STS_STAT_PASSED_BIT] = st_q.passed;
        rdata[STS_STAT_READY_BIT] = st_q.ready;
        rdata[STS_STAT_ACCESS_BIT] = st_q.access;
        rdata[STS_STAT_ACTIVE_BIT] = st_q.active;
        rdata[STS_STAT_STATE_LSB +: 3] = st_q.state;
        rdata[STS_STAT_TIMEOUT_BIT] = st_q.timeout;
      end
      STS_CFG_OFS: begin
        rdata[STS_CFG_LADDR_LSB +: 8] = st_q.laddr;
        rdata[STS_CFG_OFFSET_LSB +: 16] = st_q.offset;
        rdata[STS_CFG_SPACE_BIT] = st_q.space_active;
      end
      STS_ID_OFS: begin
        rdata = STS_ID_VALUE; // R17
      end
      default: begin
        rdata = 32'h0000_0000;
      end
    endcase
  end

  always_comb begin
    st_d = st_q;
    tmr_bus.restart = 1'b0;
    tmr_bus.run = 1'b0;
    // APB: answer in the access phase right after setup
    st_d.pready = setup;
    st_d.pslverr = setup && (!map_hit || !st_q.access);
    st_d.prdata = (setup && !pwrite && st_q.access) ? rdata : 32'h0000_0000;
    if (st_q.access && wr_ctrl) begin
      st_d.reset_bit = pwdata[STS_CTRL_RESET_BIT];
      st_d.inhibit = pwdata[STS_CTRL_INHIBIT_BIT];
      if (full_cmds) begin // R22
        st_d.active = pwdata[STS_CTRL_ACTIVATE_BIT];
        st_d.rm = pwdata[STS_CTRL_RM_BIT];
      end
    end
    if (st_q.access && wr_cfg && full_cmds) begin
      st_d.offset = pwdata[STS_CFG_OFFSET_LSB +: 16];
      st_d.space_active = pwdata[STS_CFG_SPACE_BIT];
    end
    if (tmr_bus.expired) begin
      st_d.timeout = 1'b1; // R2
    end
    case (st_q.state)
      STS_HARD_RESET: begin // R1
        st_d.passed = !HAS_INIT_SEQ;
        st_d.ready = 1'b0;
        st_d.reset_bit = 1'b0;
        st_d.inhibit = 1'b0;
        st_d.active = 1'b0;
        st_d.system_reset_asserted_seen = 1'b1;
        if (!system_reset_asserted && st_q.system_reset_asserted_seen) begin // R13
          tmr_bus.restart = 1'b1; // R25
          st_d.timeout = 1'b0;
          st_d.state = HAS_CFG_INIT ? STS_CFG_INIT : STS_SELF_TEST;
          st_d.access = !HAS_CFG_INIT;
          st_d.laddr_lock = !HAS_CFG_INIT;
          st_d.laddr = cfg_laddr;
        end
      end
      STS_CFG_INIT: begin
        tmr_bus.run = 1'b1;
        if (!st_q.laddr_lock) begin
          st_d.laddr = cfg_laddr;
        end
        if (cfg_access_en && !st_q.access) begin // R4 R18
          st_d.access = 1'b1;
          st_d.passed = 1'b0;
          st_d.ready = 1'b1;
          st_d.reset_bit = 1'b0;
          st_d.inhibit = 1'b0;
        end
        if (st_q.access && rst_set) begin // R12
          st_d.state = STS_INIT_RESET;
          st_d.active = 1'b0;
        end else if (cfg_init_fail) begin
          if (st_q.access || cfg_access_en) begin // R7
            st_d.state = STS_INIT_FAILED;
            st_d.access = 1'b1;
            st_d.ready = 1'b1;
            st_d.laddr_lock = 1'b1; // R21
          end // R3
        end else if (cfg_init_done) begin // R24
          st_d.access = 1'b1;
          st_d.ready = 1'b0;
          st_d.laddr_lock = 1'b1; // R21
          st_d.state = STS_SELF_TEST;
        end
      end
      STS_INIT_FAILED: begin // R7
        st_d.passed = 1'b0;
        st_d.ready = 1'b1;
        if (rst_set) begin // R12
          st_d.state = STS_INIT_RESET;
          st_d.active = 1'b0;
        end
      end
      STS_SELF_TEST: begin // R5
        tmr_bus.run = 1'b1;
        st_d.passed = 1'b0;
        st_d.ready = 1'b0;
        if (rst_set) begin // R10
          st_d.state = STS_SOFT_RESET;
          st_d.active = 1'b0;
        end else if (test_fail || tmr_bus.expired) begin // R6
          st_d.state = STS_FAILED;
        end else if (test_pass && comm_ready) begin // R19
          st_d.state = STS_PASSED;
          st_d.passed = 1'b1; // R9
        end
      end
      STS_FAILED: begin // R8
        st_d.passed = !HAS_INIT_SEQ; // R16
        st_d.ready = 1'b0;
        if (rst_set) begin
          st_d.state = STS_SOFT_RESET;
          st_d.active = 1'b0;
        end
      end
      STS_PASSED: begin // R9
        st_d.passed = 1'b1;
        if (rst_set) begin // R10
          st_d.state = STS_SOFT_RESET;
          st_d.active = 1'b0;
        end else if (dead) begin // R19
          st_d.state = STS_FAILED;
          st_d.passed = !HAS_INIT_SEQ;
        end
      end
      STS_SOFT_RESET: begin // R11 R20
        st_d.passed = !HAS_INIT_SEQ;
        st_d.ready = 1'b0;
        st_d.active = 1'b0;
        if (rst_clr) begin // R12
          tmr_bus.restart = 1'b1; // R25
          st_d.timeout = 1'b0;
          st_d.state = STS_SELF_TEST;
        end
      end
      STS_INIT_RESET: begin // R12
        st_d.passed = !HAS_INIT_SEQ;
        st_d.ready = 1'b1;
        st_d.active = 1'b0;
        if (rst_clr) begin
          tmr_bus.restart = 1'b1; // R25
          st_d.timeout = 1'b0;
          st_d.laddr_lock = 1'b1;
          st_d.state = STS_CFG_INIT;
        end
      end
      default: begin
        st_d.state = STS_HARD_RESET;
      end
    endcase
    // Soft reset never touches logical address, access, offset or space
    if (system_reset_asserted) begin // R1 R15
      st_d.state = STS_HARD_RESET;
      st_d.access = 1'b0;
      st_d.laddr_lock = 1'b0;
      st_d.active = 1'b0;
      st_d.passed = !HAS_INIT_SEQ;
      st_d.ready = 1'b0;
      st_d.reset_bit = 1'b0;
      st_d.inhibit = 1'b0;
      st_d.rm = 1'b0;
      st_d.laddr = STS_LADDR_RESET;
      st_d.offset = 16'h0000;
      st_d.space_active = 1'b0;
      st_d.system_reset_asserted_seen = 1'b1;
    end
    // Failure line follows passed and inhibit; LED follows passed only
    st_d.sysfail_o = 1'b0;
    st_d.sysfail_oe_n = !(HAS_INIT_SEQ && !st_d.passed && // R14 R16
                          !st_d.inhibit);
    st_d.failed_led = HAS_INIT_SEQ && !st_d.passed; // R14
    // Deactivated or reset-like states keep requests off
    st_d.irq_out = irq_req && st_d.active && // R23 R11
                   (st_d.state == STS_PASSED);
    st_d.bus_req_out = bus_req && st_d.active && // R23 R11
                       (st_d.state == STS_PASSED);
    st_d.self_test_run = (st_d.state == STS_SELF_TEST) ||
                         (st_d.state == STS_CFG_INIT && st_d.ready);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '0;
      st_q.laddr <= STS_LADDR_RESET;
      // Without the init sequence the line is never driven
      st_q.passed <= !HAS_INIT_SEQ; // R16
      st_q.sysfail_oe_n <= !HAS_INIT_SEQ;
      st_q.failed_led <= HAS_INIT_SEQ;
    end else begin
      st_q <= st_d;
    end
  end

  assign prdata = st_q.prdata;
  assign pready = st_q.pready;
  assign pslverr = st_q.pslverr;
  assign sysfail_o = st_q.sysfail_o;
  assign sysfail_oe_n = st_q.sysfail_oe_n;
  assign failed_led = st_q.failed_led;
  assign irq_out = st_q.irq_out;
  assign bus_req_out = st_q.bus_req_out;
  assign self_test_run = st_q.self_test_run;
endmodule
`default_nettype wire

// ### design/sts_pkg.sv
// Package for the self test and initialization sequencer.
// Assumes a 200 MHz pclk and an APB slave with 32-bit data.
package sts_pkg;
  // Register byte offsets
  localparam logic [11:0] STS_CTRL_OFS = 12'h000;
  localparam logic [11:0] STS_STAT_OFS = 12'h004;
  localparam logic [11:0] STS_CFG_OFS = 12'h008;
  localparam logic [11:0] STS_ID_OFS = 12'h00c;
  // Control register fields
  localparam int STS_CTRL_RESET_BIT = 0;
  localparam int STS_CTRL_INHIBIT_BIT = 1;
  localparam int STS_CTRL_ACTIVATE_BIT = 2;
  localparam int STS_CTRL_RM_BIT = 3;
  // Status register fields
  localparam int STS_STAT_PASSED_BIT = 0;
  localparam int STS_STAT_READY_BIT = 1;
  localparam int STS_STAT_ACCESS_BIT = 2;
  localparam int STS_STAT_ACTIVE_BIT = 3;
  localparam int STS_STAT_STATE_LSB = 4;
  localparam int STS_STAT_TIMEOUT_BIT = 8;
  // Configuration register fields
  localparam int STS_CFG_LADDR_LSB = 0;
  localparam int STS_CFG_OFFSET_LSB = 8;
  localparam int STS_CFG_SPACE_BIT = 24;
  // Arbitrary identity value, not tied to any maker
  localparam logic [31:0] STS_ID_VALUE = 32'h0000_5a5a;
  localparam logic [7:0] STS_LADDR_RESET = 8'hff;
  // Time limit for init plus self test
  localparam real STS_LIMIT_S = 4.9;
  localparam real STS_CLK_HZ = 200.0e6;
  localparam int STS_LIMIT_CYC = int'(STS_LIMIT_S * STS_CLK_HZ);
  localparam int STS_TMR_W = 30;

  typedef enum logic [2:0] {
    STS_HARD_RESET = 3'b000,
    STS_CFG_INIT = 3'b001,
    STS_INIT_FAILED = 3'b010,
    STS_SELF_TEST = 3'b011,
    STS_FAILED = 3'b100,
    STS_PASSED = 3'b101,
    STS_SOFT_RESET = 3'b110,
    STS_INIT_RESET = 3'b111
  } sts_state_type;
endpackage

// ### design/sts_tmr_if.sv
// Interface between the sequencer and its time limit counter.
// Assumes both ends run on pclk.
`timescale 1ns/1ps
`default_nettype none
interface sts_tmr_if;
  logic restart;
  logic run;
  logic expired;
  modport ctl (output restart, output run, input expired);
  modport tmr (input restart, input run, output expired);
endinterface
`default_nettype wire

// ### design/sts_limit_timer.sv
// Counter that flags when the init plus self test window has run out.
// Assumes pclk at the package rate; limit is a parameter for simulation.
`timescale 1ns/1ps
`default_nettype none
module sts_limit_timer
  import sts_pkg::*;
#(
  parameter int LIMIT_CYC = STS_LIMIT_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  sts_tmr_if.tmr tmr
);
  typedef struct packed {
    logic [STS_TMR_W-1:0] cnt;
    logic expired;
  } sts_tmr_st_type;

  localparam logic [STS_TMR_W-1:0] LIMIT_M1 = STS_TMR_W'(LIMIT_CYC - 1);

  sts_tmr_st_type st_q;
  sts_tmr_st_type st_d;

  // Clocked by pclk, restarted at each reset release or reset bit clear
  always_comb begin
    st_d = st_q;
    if (tmr.restart) begin // R25
      st_d.cnt = '0;
      st_d.expired = 1'b0;
    end else if (tmr.run && !st_q.expired) begin // R2
      if (st_q.cnt == LIMIT_M1) begin
        st_d.expired = 1'b1;
      end else begin
        st_d.cnt = st_q.cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign tmr.expired = st_q.expired;
endmodule
`default_nettype wire

// ### dv/sts_checker.sv
// Port-level checker for the sequencer.
// Bound to sts_sequencer; sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module sts_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic system_reset_asserted,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic irq_req,
  input wire logic bus_req,
  input wire logic sysfail_o,
  input wire logic sysfail_oe_n,
  input wire logic failed_led,
  input wire logic irq_out,
  input wire logic bus_req_out,
  input wire logic self_test_run
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_system_reset_asserted_release;
    system_reset_asserted ##1 !system_reset_asserted;
  endsequence
  property p_hard;
    system_reset_asserted [*3] |-> !sysfail_oe_n && failed_led;
  endproperty
  property p_init_line;
    s_system_reset_asserted_release |-> !sysfail_oe_n [*2];
  endproperty
  property p_irq_src;
    irq_out |-> $past(irq_req) && !failed_led;
  endproperty
  property p_bus_src;
    bus_req_out |-> $past(bus_req) && sysfail_oe_n;
  endproperty
  property p_st_quiet;
    self_test_run |-> !irq_out && !bus_req_out;
  endproperty
  property p_led_line;
    !sysfail_oe_n |-> failed_led;
  endproperty
  property p_line_val;
    !sysfail_o;
  endproperty
  property p_pready_pulse;
    pready |=> !pready;
  endproperty
  property p_answer;
    psel && !penable |=> pready;
  endproperty
  property p_slverr;
    pslverr |-> pready;
  endproperty
  a_hard: assert property (p_hard)
    else $error("hard reset not shown");
  a_init_line: assert property (p_init_line)
    else $error("line released in init");
  a_irq_src: assert property (p_irq_src)
    else $error("interrupt out of place");
  a_bus_src: assert property (p_bus_src)
    else $error("bus request out of place");
  a_st_quiet: assert property (p_st_quiet)
    else $error("requests during self test");
  a_led_line: assert property (p_led_line)
    else $error("led off while line driven");
  a_line_val: assert property (p_line_val)
    else $error("failure line driven high");
  a_pready_pulse: assert property (p_pready_pulse)
    else $error("pready longer than a cycle");
  a_answer: assert property (p_answer)
    else $error("no answer to setup");
  a_slverr: assert property (p_slverr)
    else $error("pslverr without pready");
endmodule
bind sts_sequencer sts_checker chk (.pclk(pclk), .presetn(presetn),
  .system_reset_asserted(system_reset_asserted), .psel(psel),
  .penable(penable), .pready(pready), .pslverr(pslverr),
  .irq_req(irq_req), .bus_req(bus_req), .sysfail_o(sysfail_o),
  .sysfail_oe_n(sysfail_oe_n), .failed_led(failed_led),
  .irq_out(irq_out), .bus_req_out(bus_req_out),
  .self_test_run(self_test_run));
`default_nettype wire

// ### dv/sts_cmdr_model.sv
// Commander side: an APB master that issues single transfers.
// Assumes pclk and a slave that answers with pready.
`timescale 1ns/1ps
`default_nettype none
module sts_cmdr_model (
  input wire logic pclk,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  output logic psel = 1'b0,
  output logic penable = 1'b0,
  output logic pwrite = 1'b0,
  output logic [11:0] paddr = 12'h000,
  output logic [31:0] pwdata = 32'h0
);
  task automatic xfer(input logic wr, input logic [11:0] a,
    input logic [31:0] d, output logic [31:0] rd, output logic err,
    output logic to);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    to = 1'b1;
    for (n = 0; n < 16 && to; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) begin
        to = 1'b0;
        rd = prdata;
        err = pslverr;
      end
    end
    psel <= 1'b0;
    penable <= 1'b0;
    // Released lines do not keep the old value
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule
`default_nettype wire

// ### dv/selftest_init_sequencer_tb_top.sv
// Self-checking bench for the sequencer.
// Drives device results and APB through the commander model.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin failures++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end
module selftest_init_sequencer_tb_top;
  import sts_pkg::*;
  logic pclk, psel, penable, pwrite, pready, pslverr, e, t;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic presetn = 1'b0, system_reset_asserted = 1'b1, dead = 1'b0;
  logic cfg_access_en = 1'b0, cfg_init_done = 1'b0, cfg_init_fail = 1'b0;
  logic test_pass = 1'b0, test_fail = 1'b0, comm_ready = 1'b0;
  logic irq_req = 1'b0, bus_req = 1'b0;
  logic [7:0] cfg_laddr = 8'h12;
  logic sysfail_o, sysfail_oe_n, failed_led, irq_out, bus_req_out;
  logic self_test_run;
  int failures = 0;
  int cmp_count = 0;
  sts_sequencer #(.LIMIT_CYC(100)) uut (.pclk(pclk), .presetn(presetn),
    .system_reset_asserted(system_reset_asserted), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cfg_access_en(cfg_access_en), .cfg_init_done(cfg_init_done),
    .cfg_init_fail(cfg_init_fail), .test_pass(test_pass),
    .test_fail(test_fail), .comm_ready(comm_ready), .dead(dead),
    .irq_req(irq_req), .bus_req(bus_req), .cfg_laddr(cfg_laddr),
    .sysfail_o(sysfail_o), .sysfail_oe_n(sysfail_oe_n),
    .failed_led(failed_led), .irq_out(irq_out), .bus_req_out(bus_req_out),
    .self_test_run(self_test_run));
  sts_cmdr_model cmdr (.pclk(pclk), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata));
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  task automatic end_sim;
    $display("failures=%0d compares=%0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic xf(input logic wr, input logic [11:0] a,
    input logic [31:0] d);
    cmdr.xfer(wr, a, d, r, e, t);
    if (t !== 1'b0) begin
      failures++;
      end_sim();
    end
  endtask
  task automatic stat(input sts_state_type s, input logic p);
    xf(1'b0, STS_STAT_OFS, 32'h0);
    `CHK(e, 1'b0)
    `CHK(r[STS_STAT_STATE_LSB +: 3], s)
    `CHK(r[STS_STAT_PASSED_BIT], p)
  endtask
  task automatic restart;
    xf(1'b1, STS_CTRL_OFS, 32'h1);
    xf(1'b1, STS_CTRL_OFS, 32'h0);
  endtask
  initial begin
    cyc(12);
    presetn <= 1'b1;
    cyc(3);
    `CHK({sysfail_oe_n, failed_led}, 2'b01)
    xf(1'b0, STS_STAT_OFS, 32'h0);
    `CHK(e, 1'b1)
    system_reset_asserted <= 1'b0;
    cfg_init_fail <= 1'b1;
    cyc(4);
    cfg_init_fail <= 1'b0;
    cfg_access_en <= 1'b1;
    cyc(3);
    stat(STS_CFG_INIT, 1'b0);
    `CHK(r[STS_STAT_READY_BIT], 1'b1)
    cfg_init_done <= 1'b1;
    cyc(3);
    cfg_init_done <= 1'b0;
    stat(STS_SELF_TEST, 1'b0);
    `CHK({r[STS_STAT_READY_BIT], self_test_run}, 2'b01)
    xf(1'b1, STS_CTRL_OFS, 32'h4);
    test_pass <= 1'b1;
    comm_ready <= 1'b1;
    irq_req <= 1'b1;
    bus_req <= 1'b1;
    cyc(3);
    test_pass <= 1'b0;
    stat(STS_PASSED, 1'b1);
    `CHK({sysfail_oe_n, failed_led, irq_out}, 3'b100)
    xf(1'b0, STS_ID_OFS, 32'h0);
    `CHK(r, STS_ID_VALUE)
    xf(1'b0, 12'h010, 32'h0);
    `CHK(e, 1'b1)
    xf(1'b1, STS_CTRL_OFS, 32'h4);
    cyc(2);
    `CHK({irq_out, bus_req_out}, 2'b11)
    xf(1'b1, STS_CTRL_OFS, 32'h1);
    stat(STS_SOFT_RESET, 1'b0);
    `CHK({irq_out, bus_req_out}, 2'b00)
    xf(1'b1, STS_CTRL_OFS, 32'h0);
    stat(STS_SELF_TEST, 1'b0);
    test_fail <= 1'b1;
    cyc(3);
    test_fail <= 1'b0;
    stat(STS_FAILED, 1'b0);
    `CHK(sysfail_oe_n, 1'b0)
    xf(1'b1, STS_CTRL_OFS, 32'h2);
    cyc(2);
    `CHK(sysfail_oe_n, 1'b1)
    restart();
    cyc(50);
    stat(STS_SELF_TEST, 1'b0);
    cyc(60);
    stat(STS_FAILED, 1'b0);
    `CHK(r[STS_STAT_TIMEOUT_BIT], 1'b1)
    restart();
    test_pass <= 1'b1;
    cyc(3);
    test_pass <= 1'b0;
    stat(STS_PASSED, 1'b1);
    dead <= 1'b1;
    cyc(3);
    dead <= 1'b0;
    stat(STS_FAILED, 1'b0);
    presetn <= 1'b0;
    system_reset_asserted <= 1'b1;
    cfg_access_en <= 1'b0;
    cyc(3);
    presetn <= 1'b1;
    cyc(2);
    `CHK({sysfail_oe_n, failed_led}, 2'b01)
    system_reset_asserted <= 1'b0;
    cfg_access_en <= 1'b1;
    cyc(2);
    cfg_init_fail <= 1'b1;
    cyc(3);
    cfg_init_fail <= 1'b0;
    stat(STS_INIT_FAILED, 1'b0);
    `CHK({r[STS_STAT_READY_BIT], sysfail_oe_n}, 2'b10)
    cfg_laddr <= 8'h34;
    xf(1'b1, STS_CTRL_OFS, 32'h1);
    stat(STS_INIT_RESET, 1'b0);
    xf(1'b1, STS_CTRL_OFS, 32'h0);
    stat(STS_CFG_INIT, 1'b0);
    xf(1'b0, STS_CFG_OFS, 32'h0);
    `CHK(r[STS_CFG_LADDR_LSB +: 8], 8'h12)
    end_sim();
  end
endmodule
`default_nettype wire
